// [pcm_pkg.sv]
// constants for the predictive csma media access block
package pcm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SLOTW = 8'h04;
    localparam logic [7:0] OFS_TXREQ = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    // ctrl fields
    localparam int CTRL_M_LSB = 0;
    localparam int CTRL_OWN_LSB = 8;
    localparam int CTRL_DELTA_LSB = 16;
    // txreq fields
    localparam int TXREQ_PRI_BIT = 0;
    // status fields
    localparam int ST_BL_LSB = 0;
    localparam int ST_IDLE_BIT = 8;
    localparam int ST_STATE_LSB = 10;
    localparam int ST_PPEND_LSB = 16;
    localparam int ST_NPEND_LSB = 20;
    // reset values
    localparam logic [6:0] M_RST = 7'h00;
    localparam logic [6:0] OWN_RST = 7'h00;
    localparam logic [5:0] DELTA_RST = 6'h00;
    localparam logic [9:0] SLOTW_RST = 10'h12C;
    // timing, in tenths of a bit time
    localparam int TENTHS_PER_BIT = 10;
    localparam int IDLE_BITS = 2;
    localparam logic [5:0] IDLE_TENTHS = 6'(IDLE_BITS * TENTHS_PER_BIT);
    localparam int SLOT_MIN_BITS = 2;
    localparam logic [9:0] SLOTW_MIN = 10'(SLOT_MIN_BITS * TENTHS_PER_BIT);
    // backlog and window
    localparam logic [5:0] BL_MIN = 6'h01;
    localparam logic [5:0] BL_MAX = 6'h3F;
    localparam int BASE_SLOTS = 16;
    // access states
    typedef enum logic [1:0] {PCM_WAIT, PCM_ARMED, PCM_TX} pcm_state_e;
endpackage

// [pcm_lfsr.sv]
// pseudo-random generator stepping once per enable
`timescale 1ns/1ns
module pcm_lfsr #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    output logic [W-1:0] rnd_o
);
    logic [W-1:0] lfsr_ff;
    logic [W-1:0] nxt_lfsr;

    initial begin
        if (W != 16) $error("pcm_lfsr supports W of 16 only");
    end

    always_comb begin
        nxt_lfsr = lfsr_ff;
        if (en_i) begin
            nxt_lfsr = {lfsr_ff[W-2:0],
                lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lfsr_ff <= 16'hACE1;
        end else begin
            lfsr_ff <= nxt_lfsr;
        end
    end

    assign rnd_o = lfsr_ff;
endmodule // pcm_lfsr

// [pcm_media_access.sv]
// predictive p-persistent csma media access controller with ahb-lite regs
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module pcm_media_access #(
    parameter int TICK_DIV = 1,
    parameter int PEND_W = 4
) (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic CHAN_RX_I,
    input wire logic RX_HDR_VALID_I,
    input wire logic [5:0] RX_DELTA_I,
    output logic TX_START_O,
    output logic TX_PRI_O,
    output logic [5:0] TX_DELTA_O
);
    localparam logic [PEND_W-1:0] PEND_MAX = '1;
    localparam logic [PEND_W-1:0] PEND_ONE = PEND_W'(1);
    localparam logic [9:0] LATE_TICKS = 10'h002; // arming costs a tick or two

    initial begin
        if (TICK_DIV < 1 || TICK_DIV > 65535) $error("TICK_DIV out of range");
        if (PEND_W < 1 || PEND_W > 4) $error("PEND_W must be 1 to 4");
    end

    // bus slave state
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_addr_ff, nxt_wr_addr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [6:0] m_ff, nxt_m;
    logic [6:0] own_ff, nxt_own;
    logic [5:0] delta_ff, nxt_delta;
    logic [9:0] slotw_ff, nxt_slotw;
    logic push_pri, push_npri;
    // channel sense state
    logic rx_s1_ff, rx_s2_ff, rx_s3_ff;
    logic [15:0] div_ff, nxt_div;
    logic tick;
    logic [5:0] quiet_ff, nxt_quiet;
    logic idle_q_ff;
    logic idle, pkt_end;
    logic [9:0] stick_ff, nxt_stick;
    logic [10:0] sidx_ff, nxt_sidx;
    // backlog
    logic [5:0] bl_ff, nxt_bl;
    logic [6:0] bl_sum;
    // access state
    pcm_pkg::pcm_state_e st_ff, nxt_st;
    logic [PEND_W-1:0] ppend_ff, nxt_ppend, npend_ff, nxt_npend;
    logic [10:0] tgt_ff, nxt_tgt;
    logic cur_pri_ff, nxt_cur_pri;
    logic seen_busy_ff, nxt_seen_busy;
    logic start_ff, nxt_start;
    logic pri_ff, nxt_pri;
    logic [5:0] tdelta_ff, nxt_tdelta;
    logic [15:0] rnd;
    logic [9:0] win;
    logic [25:0] prod;
    logic [10:0] draw;
    logic use_pri;
    logic fire;

    pcm_lfsr #(.W(16)) u_lfsr (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .en_i(1'b1),
        .rnd_o(rnd)
    );

    // ahb-lite slave: zero wait states, always okay
    always_comb begin
        nxt_wr_pend = 1'b0;
        nxt_wr_addr = wr_addr_ff;
        nxt_rdata = rdata_ff;
        nxt_m = m_ff;
        nxt_own = own_ff;
        nxt_delta = delta_ff;
        nxt_slotw = slotw_ff;
        push_pri = 1'b0;
        push_npri = 1'b0;
        if (wr_pend_ff) begin
            case (wr_addr_ff)
                pcm_pkg::OFS_CTRL: begin
                    nxt_m = HWDATA_I[pcm_pkg::CTRL_M_LSB +: 7];
                    nxt_own = HWDATA_I[pcm_pkg::CTRL_OWN_LSB +: 7];
                    nxt_delta = HWDATA_I[pcm_pkg::CTRL_DELTA_LSB +: 6];
                end
                pcm_pkg::OFS_SLOTW: begin
                    if (HWDATA_I[9:0] < pcm_pkg::SLOTW_MIN) begin
                        nxt_slotw = pcm_pkg::SLOTW_MIN;
                    end else begin
                        nxt_slotw = HWDATA_I[9:0];
                    end
                end
                pcm_pkg::OFS_TXREQ: begin
                    push_pri = HWDATA_I[pcm_pkg::TXREQ_PRI_BIT];
                    push_npri = !HWDATA_I[pcm_pkg::TXREQ_PRI_BIT];
                end
                default: begin
                end
            endcase
        end
        if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
            nxt_wr_pend = HWRITE_I;
            nxt_wr_addr = {HADDR_I[7:2], 2'b00};
            nxt_rdata = 32'h0000_0000;
            if (!HWRITE_I) begin
                case ({HADDR_I[7:2], 2'b00})
                    pcm_pkg::OFS_CTRL: begin
                        nxt_rdata[pcm_pkg::CTRL_M_LSB +: 7] = m_ff;
                        nxt_rdata[pcm_pkg::CTRL_OWN_LSB +: 7] = own_ff;
                        nxt_rdata[pcm_pkg::CTRL_DELTA_LSB +: 6] = delta_ff;
                    end
                    pcm_pkg::OFS_SLOTW: nxt_rdata[9:0] = slotw_ff;
                    pcm_pkg::OFS_STATUS: begin
                        nxt_rdata[pcm_pkg::ST_BL_LSB +: 6] = bl_ff;
                        nxt_rdata[pcm_pkg::ST_IDLE_BIT] = idle;
                        nxt_rdata[pcm_pkg::ST_STATE_LSB +: 2] = st_ff;
                        nxt_rdata[pcm_pkg::ST_PPEND_LSB +: PEND_W] = ppend_ff;
                        nxt_rdata[pcm_pkg::ST_NPEND_LSB +: PEND_W] = npend_ff;
                    end
                    default: nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            m_ff <= pcm_pkg::M_RST;
            own_ff <= pcm_pkg::OWN_RST;
            delta_ff <= pcm_pkg::DELTA_RST;
            slotw_ff <= pcm_pkg::SLOTW_RST;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rdata_ff <= nxt_rdata;
            m_ff <= nxt_m;
            own_ff <= nxt_own;
            delta_ff <= nxt_delta;
            slotw_ff <= nxt_slotw;
        end
    end

    assign HRDATA_O = rdata_ff;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    // channel sensing, idle detection and slot timing
    assign tick = (div_ff == 16'(TICK_DIV - 1));
    assign idle = (quiet_ff > pcm_pkg::IDLE_TENTHS);
    assign pkt_end = idle && !idle_q_ff;

    always_comb begin
        nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
        nxt_quiet = quiet_ff;
        if (rx_s2_ff != rx_s3_ff) begin
            nxt_quiet = 6'h00;
        end else if (tick && !idle) begin
            nxt_quiet = quiet_ff + 6'h01;
        end
        nxt_stick = stick_ff;
        nxt_sidx = sidx_ff;
        if (!idle) begin
            nxt_stick = 10'h000;
            nxt_sidx = 11'h000;
        end else if (tick) begin
            if (stick_ff >= slotw_ff - 10'h001) begin
                nxt_stick = 10'h000;
                if (sidx_ff != 11'h7FF) nxt_sidx = sidx_ff + 11'h001;
            end else begin
                nxt_stick = stick_ff + 10'h001;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_s1_ff <= 1'b0;
            rx_s2_ff <= 1'b0;
            rx_s3_ff <= 1'b0;
            div_ff <= 16'h0000;
            quiet_ff <= 6'h00;
            idle_q_ff <= 1'b0;
            stick_ff <= 10'h000;
            sidx_ff <= 11'h000;
        end else begin
            rx_s1_ff <= CHAN_RX_I;
            rx_s2_ff <= rx_s1_ff;
            rx_s3_ff <= rx_s2_ff;
            div_ff <= nxt_div;
            quiet_ff <= nxt_quiet;
            idle_q_ff <= idle;
            stick_ff <= nxt_stick;
            sidx_ff <= nxt_sidx;
        end
    end

    // backlog estimate
    always_comb begin
        bl_sum = {1'b0, bl_ff};
        if (RX_HDR_VALID_I) bl_sum = bl_sum + {1'b0, RX_DELTA_I};
        if (pkt_end && bl_sum > {1'b0, pcm_pkg::BL_MIN}) begin
            bl_sum = bl_sum - 7'h01;
        end
        if (bl_sum > {1'b0, pcm_pkg::BL_MAX}) begin
            nxt_bl = pcm_pkg::BL_MAX;
        end else begin
            nxt_bl = bl_sum[5:0];
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            bl_ff <= pcm_pkg::BL_MIN;
        end else begin
            bl_ff <= nxt_bl;
        end
    end

    // slot selection
    assign win = 10'(pcm_pkg::BASE_SLOTS) * {4'h0, bl_ff};
    assign prod = rnd * win;
    assign draw = {4'h0, m_ff} + {1'b0, prod[25:16]};
    assign use_pri = (ppend_ff != '0) && (own_ff != 7'h00)
        && (own_ff <= m_ff);
    assign fire = (st_ff == pcm_pkg::PCM_ARMED) && idle
        && (stick_ff <= LATE_TICKS) && (sidx_ff == tgt_ff);

    always_comb begin
        nxt_st = st_ff;
        nxt_ppend = ppend_ff;
        nxt_npend = npend_ff;
        nxt_tgt = tgt_ff;
        nxt_cur_pri = cur_pri_ff;
        nxt_seen_busy = seen_busy_ff;
        nxt_start = 1'b0;
        nxt_pri = pri_ff;
        nxt_tdelta = tdelta_ff;
        case (st_ff)
            pcm_pkg::PCM_WAIT: begin
                if (idle && (ppend_ff != '0 || npend_ff != '0)) begin
                    nxt_st = pcm_pkg::PCM_ARMED;
                    nxt_cur_pri = (ppend_ff != '0);
                    if (use_pri) begin
                        nxt_tgt = {4'h0, own_ff - 7'h01};
                    end else begin
                        nxt_tgt = draw;
                    end
                    if (nxt_tgt < sidx_ff || (nxt_tgt == sidx_ff
                            && stick_ff >= LATE_TICKS)) begin
                        nxt_tgt = sidx_ff + 11'h001;
                    end
                end
            end
            pcm_pkg::PCM_ARMED: begin
                if (!idle) begin
                    nxt_st = pcm_pkg::PCM_WAIT;
                end else if (fire) begin
                    nxt_st = pcm_pkg::PCM_TX;
                    nxt_start = 1'b1;
                    nxt_pri = cur_pri_ff;
                    nxt_tdelta = delta_ff;
                    nxt_seen_busy = 1'b0;
                    if (cur_pri_ff) begin
                        nxt_ppend = ppend_ff - PEND_ONE;
                    end else begin
                        nxt_npend = npend_ff - PEND_ONE;
                    end
                end
            end
            pcm_pkg::PCM_TX: begin
                if (!idle) begin
                    nxt_seen_busy = 1'b1;
                end else if (seen_busy_ff) begin
                    nxt_st = pcm_pkg::PCM_WAIT;
                end
            end
            default: nxt_st = pcm_pkg::PCM_WAIT;
        endcase
        if (push_pri && nxt_ppend != PEND_MAX) begin
            nxt_ppend = nxt_ppend + PEND_ONE;
        end
        if (push_npri && nxt_npend != PEND_MAX) begin
            nxt_npend = nxt_npend + PEND_ONE;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_ff <= pcm_pkg::PCM_WAIT;
            ppend_ff <= '0;
            npend_ff <= '0;
            tgt_ff <= 11'h000;
            cur_pri_ff <= 1'b0;
            seen_busy_ff <= 1'b0;
            start_ff <= 1'b0;
            pri_ff <= 1'b0;
            tdelta_ff <= 6'h00;
        end else begin
            st_ff <= nxt_st;
            ppend_ff <= nxt_ppend;
            npend_ff <= nxt_npend;
            tgt_ff <= nxt_tgt;
            cur_pri_ff <= nxt_cur_pri;
            seen_busy_ff <= nxt_seen_busy;
            start_ff <= nxt_start;
            pri_ff <= nxt_pri;
            tdelta_ff <= nxt_tdelta;
        end
    end

    assign TX_START_O = start_ff;
    assign TX_PRI_O = pri_ff;
    assign TX_DELTA_O = tdelta_ff;
endmodule // pcm_media_access

// [pcm_media_access_props.sv]
// assertions on the media access controller ports
`timescale 1ns/1ns
module pcm_media_access_props (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic CHAN_RX_I,
    input wire logic TX_START_O,
    input wire logic TX_PRI_O,
    input wire logic [5:0] TX_DELTA_O
);
    localparam int LO = 18;
    localparam int HI = 30;
    logic wp_ff, ch_ff, st_ff;
    logic [7:0] wa_ff;
    logic [6:0] m_ff, own_ff;
    logic [5:0] dl_ff;
    logic [9:0] sw_ff;
    logic [15:0] q_ff;
    // shadow of the written fields and quiet time of the raw line
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wp_ff <= 1'b0;
            wa_ff <= 8'h00;
            m_ff <= pcm_pkg::M_RST;
            own_ff <= pcm_pkg::OWN_RST;
            dl_ff <= pcm_pkg::DELTA_RST;
            sw_ff <= pcm_pkg::SLOTW_RST;
            q_ff <= 16'h0000;
            ch_ff <= 1'b1;
            st_ff <= 1'b0;
        end else begin
            wp_ff <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
            wa_ff <= HADDR_I;
            ch_ff <= CHAN_RX_I;
            q_ff <= (CHAN_RX_I != ch_ff) ? 16'h0000 :
                q_ff + 16'(q_ff != 16'hFFFF);
            st_ff <= TX_START_O || (st_ff && CHAN_RX_I == ch_ff);
            if (wp_ff && {wa_ff[7:2], 2'h0} == pcm_pkg::OFS_CTRL) begin
                m_ff <= HWDATA_I[6:0];
                own_ff <= HWDATA_I[14:8];
                dl_ff <= HWDATA_I[21:16];
            end
            if (wp_ff && {wa_ff[7:2], 2'h0} == pcm_pkg::OFS_SLOTW)
                sw_ff <= (HWDATA_I[9:0] < pcm_pkg::SLOTW_MIN) ?
                    pcm_pkg::SLOTW_MIN : HWDATA_I[9:0];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    a_start_idle: assert property (TX_START_O |-> q_ff > 16'h0014)
        else $error("start while channel not idle");
    a_start_pulse: assert property (TX_START_O |=> !TX_START_O)
        else $error("start longer than one cycle");
    a_start_once: assert property (TX_START_O |-> !st_ff)
        else $error("second start without channel activity");
    a_flag_moves: assert property (
        $changed(TX_PRI_O) || $changed(TX_DELTA_O) |-> TX_START_O)
        else $error("frame fields moved without a start");
    a_delta_value: assert property (TX_START_O |-> TX_DELTA_O == dl_ff)
        else $error("ack count differs from the configured one");
    a_pri_slot: assert property (TX_START_O && TX_PRI_O
        && own_ff != 7'h00 && own_ff <= m_ff
        |-> int'(q_ff) >= LO + (int'(own_ff) - 1) * int'(sw_ff)
        && int'(q_ff) <= HI + (int'(own_ff) - 1) * int'(sw_ff))
        else $error("priority start outside own slot");
    a_npri_after: assert property (TX_START_O
        && (!TX_PRI_O || own_ff == 7'h00 || own_ff > m_ff)
        |-> int'(q_ff) >= LO + int'(m_ff) * int'(sw_ff))
        else $error("random start inside the priority slots");
    a_window_max: assert property (TX_START_O
        |-> int'(q_ff) <= HI + (int'(m_ff) + 1008) * int'(sw_ff))
        else $error("start beyond the largest window");
endmodule // pcm_media_access_props
bind pcm_media_access pcm_media_access_props u_props (
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .CHAN_RX_I(CHAN_RX_I),
    .TX_START_O(TX_START_O), .TX_PRI_O(TX_PRI_O), .TX_DELTA_O(TX_DELTA_O)
);

// [pcm_peer.sv]
// behavioural peers and transceiver on the shared channel
`timescale 1ns/1ns
module pcm_peer #(
    parameter int LEN = 40
) (
    input wire logic clk_i,
    input wire logic tx_start_i,
    input wire logic burst_i,
    input wire logic [5:0] burst_delta_i,
    output logic chan_o,
    output logic hdr_o,
    output logic [5:0] delta_o
);
    int left = 0;
    initial chan_o = 1'b1;
    initial hdr_o = 1'b0;
    initial delta_o = 6'h00;
    always @(posedge clk_i) begin
        hdr_o <= burst_i;
        delta_o <= burst_i ? burst_delta_i : ~delta_o;
        left <= (burst_i || tx_start_i) ? LEN : (left > 0 ? left - 1 : 0);
        if (burst_i || tx_start_i || left > 1)
            chan_o <= ~chan_o;
    end
endmodule // pcm_peer

// [pcm_media_access_test.sv]
// self-checking bench for the media access controller
`timescale 1ns/1ns
module pcm_media_access_test;
    typedef struct {logic pri; int lo; int hi;} pcm_note_s;
    localparam int TLO = 18;
    localparam int THI = 30;
    localparam int W = 20;
    localparam int M = 4;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic burst = 1'b0;
    logic [5:0] bdelta = 6'h00;
    logic [31:0] rs = 32'h53;
    logic chan_d = 1'b1;
    logic [31:0] hrdata;
    logic hready, hresp, chan, hdr, tx_start, tx_pri;
    logic [5:0] rdelta, tx_delta;
    int fails = 0;
    int checks = 0;
    int quiet = 0;
    int bl = 1;
    int own = 0;
    pcm_note_s notes[$];
    pcm_note_s nt;
    always #50 clk = ~clk;
    pcm_media_access #(.TICK_DIV(1), .PEND_W(4)) uut (
        .CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .CHAN_RX_I(chan),
        .RX_HDR_VALID_I(hdr), .RX_DELTA_I(rdelta), .TX_START_O(tx_start),
        .TX_PRI_O(tx_pri), .TX_DELTA_O(tx_delta)
    );
    pcm_peer #(.LEN(40)) peer (
        .clk_i(clk), .tx_start_i(tx_start), .burst_i(burst),
        .burst_delta_i(bdelta), .chan_o(chan), .hdr_o(hdr), .delta_o(rdelta)
    );
    task summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            fails++;
        end
    endtask
    task rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (hready !== 1'b1) begin
            fails++;
            summarize();
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask
    task rd(input logic [7:0] a, input logic [31:0] mk,
        input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        chk("hresp", 32'h0, 32'(hresp));
        chk(s, e, hrdata & mk);
    endtask
    function automatic logic [5:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return {3'h0, rs[2:0]};
    endfunction
    function automatic pcm_note_s note(input logic p, input int hi);
        pcm_note_s r;
        r.pri = p;
        r.lo = TLO + M * W;
        r.hi = hi;
        if (p && own > 0 && own <= M) begin
            r.lo = TLO + (own - 1) * W;
            r.hi = THI + (own - 1) * W;
        end
        return r;
    endfunction
    task setown(input int o);
        logic [31:0] v;
        own = o;
        v = {10'h0, 6'h05, 1'b0, 7'(o), 1'b0, 7'(M)};
        bus(1'b1, pcm_pkg::OFS_CTRL, v);
        rd(pcm_pkg::OFS_CTRL, 32'hFFFFFFFF, v, "ctrl");
    endtask
    task fire(input logic [5:0] d);
        @(posedge clk);
        burst <= 1'b1;
        bdelta <= d;
        @(posedge clk);
        burst <= 1'b0;
    endtask
    // peer frame, queued requests, wait for starts, then backlog check
    task go(input int n, input logic p0, input logic [5:0] d,
        input logic again);
        int k;
        int hi;
        bl = (bl + d > 63) ? 63 : bl + d;
        hi = THI + (M + 16 * bl - 1) * W;
        fire(d);
        bus(1'b1, pcm_pkg::OFS_TXREQ, {31'h0, p0});
        if (n > 1)
            bus(1'b1, pcm_pkg::OFS_TXREQ, 32'h1);
        if (n > 1)
            notes.push_back(note(1'b1, hi));
        notes.push_back(note(p0, hi));
        if (again) begin
            repeat (75) @(posedge clk);
            fire(6'h00);
        end
        k = 0;
        while (notes.size() != 0 && k < 30000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 30000) begin
            fails++;
            summarize();
        end
        repeat (80) @(posedge clk);
        repeat (n + (again ? 2 : 1)) bl = (bl > 1) ? bl - 1 : 1;
        rd(pcm_pkg::OFS_STATUS, 32'h3F, 32'(bl), "backlog");
    endtask
    always @(posedge clk) begin
        chan_d <= chan;
        quiet <= (chan !== chan_d) ? 0 : quiet + 1;
        if (tx_start === 1'b1) begin
            if (notes.size() == 0) begin
                chk("start", 32'h0, 32'h1);
            end else begin
                nt = notes.pop_front();
                chk("pri", 32'(nt.pri), 32'(tx_pri));
                chk("delta", 32'h5, 32'(tx_delta));
                chk("slot", 32'(nt.lo), (quiet >= nt.lo && quiet <= nt.hi)
                    ? 32'(nt.lo) : 32'(quiet));
            end
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd(pcm_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl");
        rd(pcm_pkg::OFS_SLOTW, 32'h3FF, 32'h12C, "slotw");
        rd(pcm_pkg::OFS_STATUS, 32'h3F, 32'h1, "backlog");
        rd(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
        bus(1'b1, pcm_pkg::OFS_SLOTW, 32'h5);
        rd(pcm_pkg::OFS_SLOTW, 32'h3FF, 32'h14, "slotw");
        bus(1'b1, pcm_pkg::OFS_SLOTW, 32'h38);
        rd(pcm_pkg::OFS_SLOTW, 32'h3FF, 32'h38, "slotw");
        bus(1'b1, pcm_pkg::OFS_SLOTW, 32'(W));
        setown(2);
        go(1, 1'b1, rnd(), 1'b0);
        go(2, 1'b0, rnd(), 1'b0);
        setown(0);
        go(1, 1'b1, rnd(), 1'b0);
        go(1, 1'b0, rnd(), 1'b1);
        setown(3);
        go(1, 1'b1, 6'h3F, 1'b0);
        summarize();
    end
endmodule // pcm_media_access_test
